// ===== core/clock_gen_pkg.sv
// Constants for the clock generator flags and trim block
package clock_gen_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTL0 = 8'h34;
  localparam logic [7:0] IDX_CTL1 = 8'h35;
  localparam logic [7:0] IDX_MULT = 8'h36;
  localparam logic [7:0] IDX_FLAGS = 8'h37;
  localparam logic [7:0] IDX_TRIMH = 8'h38;
  localparam logic [7:0] IDX_TRIML = 8'h39;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h3C;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h3D;
  // Flags register fields
  localparam int FLG_POR = 6;
  localparam int FLG_LOCKCHG = 4;
  localparam int FLG_LOCK_STATUS = 3;
  localparam int FLG_ILLADDR = 2;
  localparam int FLG_OSCUP = 1;
  // Control register 0 fields
  localparam int C0_OSC_ENABLE = 7;
  localparam int C0_RDIV_LO = 4;
  localparam int C0_BUS_CLOCK_SOURCE_SEL = 3;
  localparam int C0_FLL_REFERENCE_SEL = 2;
  localparam int C0_OSC4 = 1;
  // Control register 1 fields
  localparam int C1_BDIV_LO = 4;
  localparam int C1_LOCK_IRQ_ENABLE = 1;
  // Interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_LOCKCHG = 0;
  localparam int IRQ_ILLADDR = 1;
  localparam int IRQ_OSCUP = 2;
  // Widths and reset values
  localparam int TRIM_W = 9;
  localparam int MULT_W = 7;
  localparam logic [7:0] CTL0_RST = 8'h00;
  localparam logic [7:0] CTL1_RST = 8'h00;
  localparam logic [6:0] MULT_RST = 7'h00;
  localparam logic [8:0] TRIM_RST = 9'h000;
  localparam logic [2:0] MASK_RST = 3'h0;
endpackage : clock_gen_pkg

// ===== core/clock_gen_flags_and_trim.sv
// Clock generator status flags, lock interrupt and reference trim with APB slave
//
// Contract
// - A power-on reset sets the power-on flag in bit 6 and a system reset leaves it alone.
// - An illegal address access sets bit 2, kept through system reset, cleared by power-on.
// - Power-on, illegal-address and lock-change flags clear only on a written 1.
// - Any change of the lock status bit, other than a clear by stop mode or a register write, sets the lock-change flag in bit 4.
// - With lock interrupt enabled, a set lock-change flag holds the interrupt request.
// - Lock status in bit 3 is read-only and shows the DCO within tolerance.
// - Stop mode or writes to control 0, multiplier or trim clear lock status silently.
// - Bit 1 sets once the enabled oscillator has finished its startup.
// - Oscillator as bus clock or FLL reference is selectable only while started up.
// - Startup status clears on oscillator disable or stop mode and ignores writes.
// - The oscillator monitor runs only while the startup status bit is set.
// - After system reset release the flash trim value is loaded into the trim registers.
// - The 9-bit trim is binary weighted; lower value gives higher reference frequency.
// - Both trim registers are readable at any time and writable except while system reset is asserted.
// - Control 0 bit 7 enables oscillator clock and monitor.
// - Control 1 bit 1 enables lock-change interrupt requests.
`timescale 1ns/1ps
module clock_gen_flags_and_trim
  import clock_gen_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sysReset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic illegalAccess,
  input wire logic stopMode,
  input wire logic dcoInTolerance,
  input wire logic oscStartupDone,
  input wire logic [TRIM_W-1:0] flashTrim,
  output logic oscEnable,
  output logic oscMonitorActive,
  output logic busClockSourceSel,
  output logic fllReferenceSel,
  output logic osc4MhzFilter,
  output logic [2:0] refDivider,
  output logic [3:0] busDivider,
  output logic [MULT_W-1:0] fllMultiplier,
  output logic [TRIM_W-1:0] refTrim,
  output logic lockIrq,
  output logic irq
);

  // Synchronisers for the analog status inputs
  logic lockSync_r;
  logic oscSync_r;
  clock_gen_sync_bit lockSync_i (
    .clk(clk),
    .reset(reset),
    .din(dcoInTolerance),
    .dout(lockSync_r)
  );
  clock_gen_sync_bit oscSync_i (
    .clk(clk),
    .reset(reset),
    .din(oscStartupDone),
    .dout(oscSync_r)
  );

  // Bus decode
  wire addrAligned = (paddr[1:0] == 2'b00);
  wire [7:0] regIdx = paddr[9:2];
  wire selCtl0 = addrAligned && (regIdx == IDX_CTL0);
  wire selCtl1 = addrAligned && (regIdx == IDX_CTL1);
  wire selMult = addrAligned && (regIdx == IDX_MULT);
  wire selFlags = addrAligned && (regIdx == IDX_FLAGS);
  wire selTrimH = addrAligned && (regIdx == IDX_TRIMH);
  wire selTrimL = addrAligned && (regIdx == IDX_TRIML);
  wire selStat = addrAligned && (regIdx == IDX_IRQ_STAT);
  wire selMask = addrAligned && (regIdx == IDX_IRQ_MASK);
  wire mapped = selCtl0 || selCtl1 || selMult || selFlags || selTrimH || selTrimL
                || selStat || selMask;
  wire access = psel && penable;
  wire setup = psel && !penable;
  wire wrLane = access && pwrite && mapped && pstrb[0];
  wire rdDone = access && !pwrite && mapped;
  wire [7:0] wb = pwdata[7:0];
  wire wrCtl0 = wrLane && selCtl0;
  wire wrCtl1 = wrLane && selCtl1;
  wire wrMult = wrLane && selMult;
  wire wrFlags = wrLane && selFlags;
  wire wrTrimH = wrLane && selTrimH;
  wire wrTrimL = wrLane && selTrimL;
  wire wrMask = wrLane && selMask;
  wire rdStat = rdDone && selStat;

  assign pready = penable;
  assign pslverr = access && !mapped;

  // Control registers
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [MULT_W-1:0] mult_r;
  logic oscStarted_r;
  wire oscOff = !ctl0_r[C0_OSC_ENABLE] || stopMode;
  logic [7:0] ctl0_nxt;
  always_comb begin
    ctl0_nxt = ctl0_r;
    if (wrCtl0) begin
      ctl0_nxt[C0_OSC_ENABLE] = wb[C0_OSC_ENABLE];
      ctl0_nxt[C0_RDIV_LO+2:C0_RDIV_LO] = wb[C0_RDIV_LO+2:C0_RDIV_LO];
      ctl0_nxt[C0_BUS_CLOCK_SOURCE_SEL] = wb[C0_BUS_CLOCK_SOURCE_SEL] && oscStarted_r;
      ctl0_nxt[C0_FLL_REFERENCE_SEL] = wb[C0_FLL_REFERENCE_SEL] && oscStarted_r;
      if (!ctl0_r[C0_OSC_ENABLE]) begin
        ctl0_nxt[C0_OSC4] = wb[C0_OSC4];
      end
    end
    if (oscOff) begin
      ctl0_nxt[C0_BUS_CLOCK_SOURCE_SEL] = 1'b0;
      ctl0_nxt[C0_FLL_REFERENCE_SEL] = 1'b0;
    end
    ctl0_nxt[0] = 1'b0;
  end
  wire [7:0] ctl1_nxt = wrCtl1 ? {wb[7:4], 2'b00, wb[C1_LOCK_IRQ_ENABLE], 1'b0} : ctl1_r;

  // Oscillator and reference control
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl0_r <= CTL0_RST;
    end else if (sysReset) begin
      ctl0_r <= CTL0_RST;
    end else begin
      ctl0_r <= ctl0_nxt;
    end
  end

  // Bus divider and lock interrupt enable
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctl1_r <= CTL1_RST;
    end else if (sysReset) begin
      ctl1_r <= CTL1_RST;
    end else begin
      ctl1_r <= ctl1_nxt;
    end
  end

  // Loop multiplier
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mult_r <= MULT_RST;
    end else if (sysReset) begin
      mult_r <= MULT_RST;
    end else if (wrMult) begin
      mult_r <= wb[MULT_W-1:0];
    end
  end

  // Oscillator startup status
  wire oscStarted_nxt = oscOff ? 1'b0 : (oscStarted_r || oscSync_r);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscStarted_r <= 1'b0;
    end else if (sysReset) begin
      oscStarted_r <= 1'b0;
    end else begin
      oscStarted_r <= oscStarted_nxt;
    end
  end

  // Trim registers with flash load after system reset
  logic [TRIM_W-1:0] trim_r;
  logic loadPending_r;
  logic [TRIM_W-1:0] trim_nxt;
  always_comb begin
    trim_nxt = trim_r;
    if (loadPending_r) begin
      trim_nxt = flashTrim;
    end
    if (wrTrimH) begin
      trim_nxt[8] = wb[0];
    end
    if (wrTrimL) begin
      trim_nxt[7:0] = wb;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      trim_r <= TRIM_RST;
    end else if (!sysReset) begin
      trim_r <= trim_nxt;
    end
  end

  // Load request armed by either reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loadPending_r <= 1'b1;
    end else if (sysReset) begin
      loadPending_r <= 1'b1;
    end else begin
      loadPending_r <= 1'b0;
    end
  end

  // Lock status tracking
  wire lockClear = stopMode || wrCtl0 || wrMult || wrTrimH || wrTrimL;
  logic lock_status_r;
  logic relockHold_r;
  wire lock_status_nxt = lockSync_r && !relockHold_r && !lockClear;
  wire lockChange = !lockClear && (lock_status_nxt != lock_status_r);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lock_status_r <= 1'b0;
    end else begin
      lock_status_r <= lock_status_nxt;
    end
  end

  // Hold lock status low until tolerance drops after a clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      relockHold_r <= 1'b0;
    end else begin
      relockHold_r <= lockClear || (relockHold_r && lockSync_r);
    end
  end

  // Sticky flags; a set in the same cycle wins over the written 1
  logic porFlag_r;
  logic illAddrFlag_r;
  logic lockChgFlag_r;
  clock_gen_sticky_flag #(
    .RESET_VAL(1'b1)
  ) porFlag_i (
    .clk(clk),
    .reset(reset),
    .setEvent(1'b0),
    .clearReq(wrFlags && wb[FLG_POR]),
    .flag(porFlag_r)
  );
  clock_gen_sticky_flag #(
    .RESET_VAL(1'b0)
  ) illAddrFlag_i (
    .clk(clk),
    .reset(reset),
    .setEvent(illegalAccess),
    .clearReq(wrFlags && wb[FLG_ILLADDR]),
    .flag(illAddrFlag_r)
  );
  clock_gen_sticky_flag #(
    .RESET_VAL(1'b0)
  ) lockChgFlag_i (
    .clk(clk),
    .reset(reset),
    .setEvent(lockChange),
    .clearReq(wrFlags && wb[FLG_LOCKCHG]),
    .flag(lockChgFlag_r)
  );

  // Interrupt status, cleared by read; set wins over clear
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic oscStartedDly_r;
  wire [IRQ_W-1:0] irqEvents = {oscStarted_r && !oscStartedDly_r, illegalAccess, lockChange};
  for (genvar b = 0; b < IRQ_W; b++) begin : irqStatBit
    clock_gen_sticky_flag #(
      .RESET_VAL(1'b0)
    ) statFlag_i (
      .clk(clk),
      .reset(reset),
      .setEvent(irqEvents[b]),
      .clearReq(rdStat),
      .flag(irqStat_r[b])
    );
  end

  // Interrupt mask
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irqMask_r <= MASK_RST;
    end else if (wrMask) begin
      irqMask_r <= wb[IRQ_W-1:0];
    end
  end

  // Startup edge detector
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      oscStartedDly_r <= 1'b0;
    end else begin
      oscStartedDly_r <= oscStarted_r;
    end
  end

  // Read data, captured in the setup phase
  wire [7:0] flagsRd = {1'b0, porFlag_r, 1'b0, lockChgFlag_r, lock_status_r, illAddrFlag_r,
                        oscStarted_r, 1'b0};
  wire [7:0] rdByte =
      selCtl0 ? ctl0_r :
      selCtl1 ? ctl1_r :
      selMult ? {1'b0, mult_r} :
      selFlags ? flagsRd :
      selTrimH ? {7'h00, trim_r[8]} :
      selTrimL ? trim_r[7:0] :
      selStat ? {5'h00, irqStat_r} :
      selMask ? {5'h00, irqMask_r} : 8'h00;
  logic [DATA_W-1:0] prdata_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_r <= '0;
    end else if (setup && !pwrite) begin
      prdata_r <= {24'h00_0000, rdByte};
    end
  end
  assign prdata = prdata_r;

  // Outputs to the clock system
  assign oscEnable = ctl0_r[C0_OSC_ENABLE];
  assign oscMonitorActive = oscStarted_r;
  assign busClockSourceSel = ctl0_r[C0_BUS_CLOCK_SOURCE_SEL];
  assign fllReferenceSel = ctl0_r[C0_FLL_REFERENCE_SEL];
  assign osc4MhzFilter = ctl0_r[C0_OSC4];
  assign refDivider = ctl0_r[C0_RDIV_LO+2:C0_RDIV_LO];
  assign busDivider = ctl1_r[C1_BDIV_LO+3:C1_BDIV_LO];
  assign fllMultiplier = mult_r;
  assign refTrim = trim_r;
  assign lockIrq = lockChgFlag_r && ctl1_r[C1_LOCK_IRQ_ENABLE];
  assign irq = |(irqStat_r & irqMask_r);

endmodule : clock_gen_flags_and_trim

// Two-stage synchroniser for an asynchronous level
module clock_gen_sync_bit (
  input wire logic clk,
  input wire logic reset,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  logic sync_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end
  assign dout = sync_r;
endmodule : clock_gen_sync_bit

// Sticky event flag; a set in the same cycle wins over the clear
module clock_gen_sticky_flag #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic setEvent,
  input wire logic clearReq,
  output logic flag
);
  logic flag_r;
  wire flag_nxt = setEvent || (flag_r && !clearReq);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_r <= RESET_VAL;
    end else begin
      flag_r <= flag_nxt;
    end
  end
  assign flag = flag_r;
endmodule : clock_gen_sticky_flag

// ===== dv/clock_gen_flags_and_trim_asserts.sv
// Port-level checker for the clock generator flags and trim block
`timescale 1ns/1ps
module clock_gen_flags_and_trim_asserts
  import clock_gen_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sysReset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stopMode,
  input wire logic [TRIM_W-1:0] flashTrim,
  input wire logic oscEnable,
  input wire logic oscMonitorActive,
  input wire logic busClockSourceSel,
  input wire logic fllReferenceSel,
  input wire logic [TRIM_W-1:0] refTrim
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_OSC_OFF: assert property (!oscEnable |=> !oscMonitorActive)
    else $error("monitor on with oscillator off");
  AST_STOP: assert property (stopMode |=> !oscMonitorActive)
    else $error("monitor on after stop");
  AST_MON_ON: assert property ($rose(oscMonitorActive) |-> $past(oscEnable))
    else $error("monitor rose while disabled");
  AST_SEL: assert property (!oscMonitorActive |-> !busClockSourceSel && !fllReferenceSel)
    else $error("oscillator selected before startup");
  AST_TRIM_LOAD: assert property ($fell(sysReset) |=> refTrim == $past(flashTrim))
    else $error("trim not loaded after reset");
  AST_TRIM_HOLD: assert property (sysReset |=> $stable(refTrim))
    else $error("trim moved during reset");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access not answered");
  AST_ERR_DATA: assert property (pslverr && !pwrite |-> prdata == '0)
    else $error("error read with data");
  AST_MISALIGN: assert property (psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access accepted");
  COV_MON: cover property ($rose(oscMonitorActive));
  COV_ERR: cover property (pslverr);
  COV_LOAD: cover property ($fell(sysReset));
endmodule : clock_gen_flags_and_trim_asserts

bind clock_gen_flags_and_trim clock_gen_flags_and_trim_asserts clock_gen_flags_and_trim_asserts_i (
  .clk(clk), .reset(reset), .sysReset(sysReset), .psel(psel), .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .stopMode(stopMode),
  .flashTrim(flashTrim), .oscEnable(oscEnable), .oscMonitorActive(oscMonitorActive),
  .busClockSourceSel(busClockSourceSel), .fllReferenceSel(fllReferenceSel), .refTrim(refTrim)
);

// ===== dv/clock_gen_flags_and_trim_test.sv
// Self-checking bench for the clock generator flags and trim block
`timescale 1ns/1ps
module clock_gen_flags_and_trim_test
  import clock_gen_pkg::*;
;
  logic clk = 0, reset = 1, sysReset = 0, psel = 0, penable = 0, pwrite = 0;
  logic illegalAccess = 0, stopMode = 0, dcoInTolerance = 0, oscStartupDone = 0, er;
  logic [9:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, d, rs = 32'h0000_252e;
  logic [3:0] pstrb = 4'h1;
  logic [8:0] flashTrim = 9'h155, refTrim, t;
  logic pready, pslverr, oscEnable, oscMonitorActive, busClockSourceSel, fllReferenceSel;
  logic osc4MhzFilter, lockIrq, irq;
  logic [2:0] refDivider;
  logic [3:0] busDivider;
  logic [6:0] fllMultiplier;
  int failCount = 0, testsRun = 0;
  clock_gen_flags_and_trim clock_gen_flags_and_trim_i (.*);
  always #5 clk = ~clk;
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic stopTest;
    if (failCount == 0 && testsRun > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stopTest
  task automatic chk(input string n, input logic [31:0] s, x);
    testsRun++;
    if (s !== x) begin
      failCount++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic xf(input logic w, input logic [7:0] i, v, output logic [31:0] r,
                    output logic e);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {24'h00_0000, v};
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      failCount++;
      stopTest;
    end
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask : xf
  task automatic wr(input logic [7:0] i, v);
    xf(1, i, v, d, er);
  endtask : wr
  task automatic rc(input string n, input logic [7:0] i, x);
    xf(0, i, 8'h00, d, er);
    chk(n, d, {24'h00_0000, x});
  endtask : rc
  initial begin
    repeat (6) @(posedge clk);
    reset <= 0;
    repeat (2) @(posedge clk);
    chk("trim", refTrim, flashTrim);
    rc("flags", IDX_FLAGS, 8'h40);
    wr(IDX_FLAGS, 8'hBF);
    rc("flags", IDX_FLAGS, 8'h40);
    wr(IDX_FLAGS, 8'h40);
    rc("flags", IDX_FLAGS, 8'h00);
    rs = nx(rs);
    illegalAccess <= 1;
    sysReset <= 1;
    flashTrim <= rs[8:0];
    @(posedge clk);
    illegalAccess <= 0;
    sysReset <= 0;
    repeat (2) @(posedge clk);
    chk("trim", refTrim, rs[8:0]);
    rc("flags", IDX_FLAGS, 8'h04);
    wr(IDX_FLAGS, 8'h04);
    dcoInTolerance <= 1;
    repeat (5) @(posedge clk);
    rc("flags", IDX_FLAGS, 8'h18);
    chk("lockIrq", lockIrq, 0);
    wr(IDX_CTL1, 8'h02);
    chk("lockIrq", lockIrq, 1);
    wr(IDX_IRQ_MASK, 8'h01);
    chk("irq", irq, 1);
    rc("irqStat", IDX_IRQ_STAT, 8'h03);
    chk("irq", irq, 0);
    wr(IDX_FLAGS, 8'h08);
    rc("flags", IDX_FLAGS, 8'h18);
    wr(IDX_FLAGS, 8'h10);
    chk("lockIrq", lockIrq, 0);
    wr(IDX_MULT, rs[15:8]);
    chk("mult", fllMultiplier, rs[14:8]);
    rc("flags", IDX_FLAGS, 8'h00);
    wr(IDX_IRQ_MASK, 8'h00);
    dcoInTolerance <= 0;
    repeat (5) @(posedge clk);
    dcoInTolerance <= 1;
    repeat (5) @(posedge clk);
    chk("irq", irq, 0);
    wr(IDX_IRQ_MASK, 8'h01);
    chk("irq", irq, 1);
    wr(IDX_CTL0, 8'h8C);
    chk("bclk", busClockSourceSel, 0);
    oscStartupDone <= 1;
    repeat (5) @(posedge clk);
    chk("mon", oscMonitorActive, 1);
    rc("flags", IDX_FLAGS, 8'h12);
    wr(IDX_CTL0, 8'h8C);
    chk("fll_reference_sel", {busClockSourceSel, fllReferenceSel}, 2'b11);
    stopMode <= 1;
    repeat (2) @(posedge clk);
    chk("mon", {oscMonitorActive, busClockSourceSel}, 2'b00);
    stopMode <= 0;
    wr(IDX_CTL0, 8'h00);
    @(posedge clk);
    chk("osc_enable", {oscEnable, oscMonitorActive}, 2'b00);
    chk("rdiv", {refDivider, osc4MhzFilter}, 4'h0);
    for (int n = 0; n < 8; n++) begin
      rs = nx(rs);
      t = rs[8:0];
      wr(IDX_TRIMH, {rs[15:9], t[8]});
      wr(IDX_TRIML, t[7:0]);
      chk("refTrim", refTrim, t);
      rc("trimH", IDX_TRIMH, {7'h00, t[8]});
      rc("trimL", IDX_TRIML, t[7:0]);
    end
    xf(0, 8'h3A, 8'h00, d, er);
    chk("err", er, 1);
    chk("errData", d, 0);
    stopTest;
  end
endmodule : clock_gen_flags_and_trim_test
